// ===== freq_element.sv
/*
 * One frequency protection element with an AHB-Lite register slave.
 * Assumes per-channel voltage magnitudes, period frequencies and a period-end strobe,
 * all synchronous to clk, from a measurement front end.
 */
// The register addresses and the AHB-Lite register port were decided locally.
// Behaviour
// - Star or delta selects the three channels
// - Under/over block only when all voltages low
// - Gradient and interval modes block on any low
// - Frequency pickup raises alarm, starts delay
// - Trip only if pickup holds; none blocked
// - One new gradient per mains period
// - Gradient needs several same-sign evaluations
// - Rising frequency positive, falling negative
// - Direction: rise, fall, or absolute magnitude
// - Gradient mode alarms at once, trips after delay
// - Combined modes need frequency and gradient together
// - Combined trip needs both at expiry
// - Interval modes hold pickup, change, interval
// - Interval pickup raises alarm, starts interval timer
// - Trip when change reached within interval
// - Interval expiry inhibits until new crossing
// - Function chosen from the nine modes
// - Measured frequency averages valid phases only
`include "freq_element_defs.svh"
`default_nettype none

module freq_element #(
	parameter int FW = 16,
	parameter int TW = 24
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic      [31:0]        hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	input  wire logic [FW-1:0]      lineVoltageAb,
	input  wire logic [FW-1:0]      lineVoltageBc,
	input  wire logic [FW-1:0]      lineVoltageCa,
	input  wire logic [FW-1:0]      phaseVoltageA,
	input  wire logic [FW-1:0]      phaseVoltageB,
	input  wire logic [FW-1:0]      phaseVoltageC,
	input  wire logic [3*FW-1:0]    lineFreq,
	input  wire logic [3*FW-1:0]    phaseFreq,
	input  wire logic [2:0]         linePeriodDone,
	input  wire logic [2:0]         phasePeriodDone,
	input  wire logic               extBlock,
	output logic                    alarm,
	output logic                    trip
);

	// Register storage
	logic [31:0]   ctrl_q;
	logic [FW-1:0] pickup_q, gradThr_q, changeThr_q, uvLevel_q, avgFreq_q;
	logic [TW-1:0] delay_q, interval_q, cnt_q;
	logic          wrPend_q;
	logic [7:0]    wrAddr_q;
	freq_element_pkg::state_e state_q, state_d;
	logic [FW-1:0] refFreq_q;

	freq_element_pkg::mode_e      mode;
	freq_element_pkg::direction_e dir;
	assign mode = freq_element_pkg::mode_e'(ctrl_q[`FE_CTRL_MODE_LSB +: 4]);
	assign dir  = freq_element_pkg::direction_e'(ctrl_q[`FE_CTRL_DIR_LSB +: 2]);

	logic isUnder, isOver, isGrad, isFreqOnly, isInterval, active;
	assign isUnder = mode == freq_element_pkg::MODE_UNDER || mode == freq_element_pkg::MODE_UNDER_GRAD
		|| mode == freq_element_pkg::MODE_UNDER_INTERVAL;
	assign isOver = mode == freq_element_pkg::MODE_OVER || mode == freq_element_pkg::MODE_OVER_GRAD
		|| mode == freq_element_pkg::MODE_OVER_INTERVAL;
	assign isGrad = mode == freq_element_pkg::MODE_UNDER_GRAD
		|| mode == freq_element_pkg::MODE_OVER_GRAD || mode == freq_element_pkg::MODE_GRAD_ONLY;
	assign isFreqOnly = mode == freq_element_pkg::MODE_UNDER || mode == freq_element_pkg::MODE_OVER;
	assign isInterval = mode == freq_element_pkg::MODE_UNDER_INTERVAL
		|| mode == freq_element_pkg::MODE_OVER_INTERVAL;
	assign active = isUnder || isOver || mode == freq_element_pkg::MODE_GRAD_ONLY;

	// Channel selection by transformer wiring
	logic [3*FW-1:0] volts, freqs;
	logic [2:0]      strobe, low, freqHit, gradHit, phaseHit;
	assign volts  = ctrl_q[`FE_CTRL_STAR_BIT] ? {phaseVoltageC, phaseVoltageB, phaseVoltageA}
		: {lineVoltageCa, lineVoltageBc, lineVoltageAb};
	assign freqs  = ctrl_q[`FE_CTRL_STAR_BIT] ? phaseFreq : lineFreq;
	assign strobe = ctrl_q[`FE_CTRL_STAR_BIT] ? phasePeriodDone : linePeriodDone;

	// Per-phase gradient, sign run and threshold checks
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gPhase
			logic [FW-1:0]   prev_q;
			logic signed [FW:0] grad_q, mag;
			logic [1:0]      run_q;
			logic            neg_q, confirmed;
			logic [FW-1:0]   f;
			assign f   = freqs[g*FW +: FW];
			assign low[g] = volts[g*FW +: FW] < uvLevel_q;
			assign mag = grad_q[FW] ? -grad_q : grad_q;
			assign confirmed = run_q >= 2'(`FE_SIGN_RUNS);
			assign freqHit[g] = !low[g] && (isUnder ? f < pickup_q : (isOver && f > pickup_q));
			always_comb begin
				gradHit[g] = 1'b0;
				case (dir)
					freq_element_pkg::DIR_RISE: gradHit[g] = !grad_q[FW]
						&& grad_q > $signed({1'b0, gradThr_q});
					freq_element_pkg::DIR_FALL: gradHit[g] = grad_q[FW]
						&& mag > $signed({1'b0, gradThr_q});
					default: gradHit[g] = mag > $signed({1'b0, gradThr_q});
				endcase
				gradHit[g] = gradHit[g] && confirmed && !low[g];
			end
			// New gradient at each period end, positive when rising
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					prev_q <= '0;
					grad_q <= '0;
					run_q  <= '0;
					neg_q  <= 1'b0;
				end else if (strobe[g]) begin
					prev_q <= f;
					grad_q <= $signed({1'b0, f}) - $signed({1'b0, prev_q});
					neg_q  <= f < prev_q;
					// A flat period breaks the run; the next slope counts from one
					if (f == prev_q)
						run_q <= 2'd0;
					else if ((f < prev_q) != neg_q)
						run_q <= 2'd1;
					else if (run_q != 2'(`FE_SIGN_RUNS))
						run_q <= run_q + 2'd1;
				end
			end
			a_sign_confirm: assert property (@(posedge clk) disable iff (rst)
				gradHit[g] |-> run_q == 2'(`FE_SIGN_RUNS))
				else $error("gradient accepted before sign run complete");
		end
	endgenerate

	// Undervoltage and external blocking
	logic blocked;
	assign blocked = extBlock || (isFreqOnly ? &low : |low);

	// Pickup condition per mode
	assign phaseHit = isGrad ? (mode == freq_element_pkg::MODE_GRAD_ONLY ? gradHit
		: freqHit & gradHit) : freqHit;
	logic pickup;
	assign pickup = active && |phaseHit;

	// Average of valid phase frequencies
	logic [FW+1:0] fsum;
	logic [1:0]    nValid;
	logic [FW-1:0] avg;
	always_comb begin
		fsum   = '0;
		nValid = '0;
		for (int i = 0; i < 3; i++) begin
			if (!low[i]) begin
				fsum   = fsum + (FW+2)'(freqs[i*FW +: FW]);
				nValid = nValid + 2'd1;
			end
		end
		case (nValid)
			2'd1: avg = fsum[FW-1:0];
			2'd2: avg = fsum[FW:1];
			2'd3: avg = FW'(fsum / (FW+2)'(3));
			default: avg = '0;
		endcase
	end

	// Change since interval start in the watched direction
	logic changeReached;
	assign changeReached = isUnder ? (refFreq_q >= avg && refFreq_q - avg >= changeThr_q)
		: (avg >= refFreq_q && avg - refFreq_q >= changeThr_q);

	logic [TW-1:0] limit;
	assign limit = isInterval ? interval_q : delay_q;

	// Pickup, timing, trip and inhibit sequence
	always_comb begin
		state_d = state_q;
		case (state_q)
			freq_element_pkg::ST_IDLE:
				if (pickup && !blocked)
					state_d = freq_element_pkg::ST_TIMING;
			freq_element_pkg::ST_TIMING:
				if (!pickup || blocked)
					state_d = freq_element_pkg::ST_IDLE;
				else if (isInterval && changeReached)
					state_d = freq_element_pkg::ST_TRIPPED;
				else if (cnt_q >= limit)
					state_d = isInterval ? freq_element_pkg::ST_INHIBIT
						: freq_element_pkg::ST_TRIPPED;
			freq_element_pkg::ST_TRIPPED:
				if (!pickup || blocked)
					state_d = freq_element_pkg::ST_IDLE;
			freq_element_pkg::ST_INHIBIT:
				if (!pickup)
					state_d = freq_element_pkg::ST_IDLE;
			default: state_d = freq_element_pkg::ST_IDLE;
		endcase
	end

	// State, timer, reference frequency and outputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q   <= freq_element_pkg::ST_IDLE;
			cnt_q     <= '0;
			refFreq_q <= '0;
			alarm     <= 1'b0;
			trip      <= 1'b0;
			avgFreq_q <= '0;
		end else begin
			state_q   <= state_d;
			avgFreq_q <= avg;
			cnt_q     <= state_d == freq_element_pkg::ST_TIMING && state_q == state_d
				? cnt_q + TW'(1) : '0;
			if (state_q == freq_element_pkg::ST_IDLE)
				refFreq_q <= avg;
			alarm <= state_d == freq_element_pkg::ST_TIMING
				|| state_d == freq_element_pkg::ST_TRIPPED;
			trip  <= state_d == freq_element_pkg::ST_TRIPPED;
		end
	end

	// AHB-Lite address phase capture and read data
	logic addrTake;
	logic [31:0] rdMux;
	assign addrTake = hsel && hready && htrans[1];
	always_comb begin
		case (haddr[7:0])
			`FE_CTRL_OFS:     rdMux = {25'h0, ctrl_q[6:0]};
			`FE_PICKUP_OFS:   rdMux = 32'(pickup_q);
			`FE_GRAD_OFS:     rdMux = 32'(gradThr_q);
			`FE_CHANGE_OFS:   rdMux = 32'(changeThr_q);
			`FE_DELAY_OFS:    rdMux = 32'(delay_q);
			`FE_INTERVAL_OFS: rdMux = 32'(interval_q);
			`FE_UVLEVEL_OFS:  rdMux = 32'(uvLevel_q);
			`FE_STATUS_OFS:   rdMux = {avgFreq_q, 8'h00, 2'(state_q), 1'b0, blocked, 2'b00,
				trip, alarm};
			default:          rdMux = 32'h0000_0000;
		endcase
		if (haddr[31:8] != 24'h00_0000)
			rdMux = 32'h0000_0000;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPend_q  <= 1'b0;
			wrAddr_q  <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wrPend_q <= addrTake && hwrite && haddr[31:8] == 24'h00_0000;
			if (addrTake)
				wrAddr_q <= haddr[7:0];
			if (addrTake && !hwrite)
				hrdata <= rdMux;
		end
	end

	// Register writes in the data phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q      <= `FE_CTRL_RST;
			pickup_q    <= `FE_PICKUP_RST;
			gradThr_q   <= `FE_GRAD_RST;
			changeThr_q <= `FE_CHANGE_RST;
			delay_q     <= `FE_DELAY_RST;
			interval_q  <= `FE_INTERVAL_RST;
			uvLevel_q   <= `FE_UVLEVEL_RST;
		end else if (wrPend_q) begin
			case (wrAddr_q)
				`FE_CTRL_OFS:     ctrl_q      <= {25'h0, hwdata[6:0]};
				`FE_PICKUP_OFS:   pickup_q    <= hwdata[FW-1:0];
				`FE_GRAD_OFS:     gradThr_q   <= hwdata[FW-1:0];
				`FE_CHANGE_OFS:   changeThr_q <= hwdata[FW-1:0];
				`FE_DELAY_OFS:    delay_q     <= hwdata[TW-1:0];
				`FE_INTERVAL_OFS: interval_q  <= hwdata[TW-1:0];
				`FE_UVLEVEL_OFS:  uvLevel_q   <= hwdata[FW-1:0];
				default:          ;
			endcase
		end
	end

	// Checks beside the sequence
	a_uv_all_block: assert property (@(posedge clk) disable iff (rst)
		(isFreqOnly && &low) |=> !alarm && !trip)
		else $error("under/over not blocked with all phases low");
	a_uv_any_block: assert property (@(posedge clk) disable iff (rst)
		(!isFreqOnly && |low) |=> !alarm)
		else $error("alarm with one phase low in gradient or interval mode");
	a_alarm_pickup: assert property (@(posedge clk) disable iff (rst)
		(!isInterval && pickup && !blocked) |=> alarm)
		else $error("alarm missing after pickup");
	a_block_quiet: assert property (@(posedge clk) disable iff (rst)
		blocked |=> !alarm && !trip)
		else $error("alarm or trip while blocked");
	a_trip_delay: assert property (@(posedge clk) disable iff (rst)
		(!isInterval && $rose(trip)) |-> $past(cnt_q) >= $past(limit) && $past(pickup))
		else $error("trip before delay expiry");
	a_drop_clears: assert property (@(posedge clk) disable iff (rst)
		!pickup |=> !alarm && !trip && cnt_q == '0)
		else $error("alarm or timer held after drop");
	a_inhibit_quiet: assert property (@(posedge clk) disable iff (rst)
		state_q == freq_element_pkg::ST_INHIBIT |-> !alarm && !trip)
		else $error("output while inhibited");
	a_interval_trip: assert property (@(posedge clk) disable iff (rst)
		(isInterval && state_q == freq_element_pkg::ST_TIMING && pickup && !blocked
		&& changeReached) |=> trip)
		else $error("interval change reached without trip");

endmodule // freq_element

`default_nettype wire

// ===== freq_element_defs.svh
/*
 * Register offsets, field positions, reset values and counts for the frequency element.
 * Assumes inclusion by bare name from the element module and the bench.
 */
`ifndef FREQ_ELEMENT_DEFS_SVH
`define FREQ_ELEMENT_DEFS_SVH

// Register byte offsets
`define FE_CTRL_OFS       8'h00
`define FE_PICKUP_OFS     8'h04
`define FE_GRAD_OFS       8'h08
`define FE_CHANGE_OFS     8'h0c
`define FE_DELAY_OFS      8'h10
`define FE_INTERVAL_OFS   8'h14
`define FE_UVLEVEL_OFS    8'h18
`define FE_STATUS_OFS     8'h1c

// Control fields
`define FE_CTRL_MODE_LSB  0
`define FE_CTRL_DIR_LSB   4
`define FE_CTRL_STAR_BIT  6

// Reset values
`define FE_CTRL_RST       32'h0000_0040
`define FE_PICKUP_RST     16'hc350
`define FE_GRAD_RST       16'h01f4
`define FE_CHANGE_RST     16'h03e8
`define FE_DELAY_RST      24'h00_0064
`define FE_INTERVAL_RST   24'h00_0064
`define FE_UVLEVEL_RST    16'h05dc

// Successive same-sign gradients needed
`define FE_SIGN_RUNS      3

`endif

// ===== freq_element_pkg.sv
/*
 * Types shared by the frequency element: function modes, gradient directions, states.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package freq_element_pkg;

	// Function selection, in the order of the mode field codes
	typedef enum logic [3:0] {
		MODE_UNUSED, MODE_UNDER, MODE_OVER, MODE_UNDER_GRAD, MODE_OVER_GRAD,
		MODE_UNDER_INTERVAL, MODE_OVER_INTERVAL, MODE_GRAD_ONLY, MODE_VECTOR_SURGE
	} mode_e;

	// Gradient direction setting
	typedef enum logic [1:0] {
		DIR_RISE, DIR_FALL, DIR_ABS
	} direction_e;

	// Pickup sequence
	typedef enum logic [1:0] {
		ST_IDLE, ST_TIMING, ST_TRIPPED, ST_INHIBIT
	} state_e;

endpackage

`default_nettype wire

// ===== freq_source_model.sv
/* Partner model: three-channel voltage transformer front end, one strobe per mains period.
   Assumes the bench sets levels and frequencies; star picks which set is wired. */
`default_nettype none

module freq_source_model #(
	parameter int PER = 6
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        star,
	input  wire logic [47:0] volts,
	input  wire logic [47:0] freqs,
	output logic      [15:0] lineVoltageAb,
	output logic      [15:0] lineVoltageBc,
	output logic      [15:0] lineVoltageCa,
	output logic      [15:0] phaseVoltageA,
	output logic      [15:0] phaseVoltageB,
	output logic      [15:0] phaseVoltageC,
	output logic      [47:0] lineFreq,
	output logic      [47:0] phaseFreq,
	output logic      [2:0]  linePeriodDone,
	output logic      [2:0]  phasePeriodDone
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_q;
	logic       tick;

	// Free-running mains period
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= (cnt_q == 8'(PER - 1)) ? 8'h00 : cnt_q + 8'h01;
		end
	end

	// Unwired set shows inverted values, so a wrong pick never looks right
	assign tick = (cnt_q == 8'(PER - 1));
	assign {lineVoltageCa, lineVoltageBc, lineVoltageAb} = star ? ~volts : volts;
	assign {phaseVoltageC, phaseVoltageB, phaseVoltageA} = star ? volts : ~volts;
	assign lineFreq        = star ? ~freqs : freqs;
	assign phaseFreq       = star ? freqs : ~freqs;
	assign linePeriodDone  = {3{tick & ~star}};
	assign phasePeriodDone = {3{tick & star}};
endmodule // freq_source_model

`default_nettype wire

// ===== frequency_protection_element_tb.sv
/* Self-checking bench: registers over AHB-Lite and every pickup mode of the element.
   Assumes the front-end model drives the measurement side. */
`include "freq_element_defs.svh"
`default_nettype none

module frequency_protection_element_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PER = 6;
	localparam int DLY = 2;
	localparam int IVL = 20;
	localparam int P   = `FE_PICKUP_RST;
	logic        clk, rst, hsel, hwrite, extBlock, star, alarm, trip, hreadyout, hresp;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [15:0] vab, vbc, vca, va, vb, vc;
	logic [47:0] volts, freqs, lf, pf;
	logic [2:0]  lpd, ppd;
	logic [7:0]  ofs [7];
	logic [31:0] rsv [7];
	int          numErrors, nTests, f, m, sg;

	freq_source_model #(.PER(PER)) u_src (.clk(clk), .rst(rst), .star(star), .volts(volts),
		.freqs(freqs), .lineVoltageAb(vab), .lineVoltageBc(vbc), .lineVoltageCa(vca),
		.phaseVoltageA(va), .phaseVoltageB(vb), .phaseVoltageC(vc), .lineFreq(lf),
		.phaseFreq(pf), .linePeriodDone(lpd), .phasePeriodDone(ppd));
	freq_element u_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lineVoltageAb(vab),
		.lineVoltageBc(vbc), .lineVoltageCa(vca), .phaseVoltageA(va), .phaseVoltageB(vb),
		.phaseVoltageC(vc), .lineFreq(lf), .phaseFreq(pf), .linePeriodDone(lpd),
		.phasePeriodDone(ppd), .extBlock(extBlock), .alarm(alarm), .trip(trip));

	// Clock and watchdog
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#300us;
		numErrors++;
		close_out();
	end

	task automatic close_out();
		$display("Checks %0d, mismatches %0d", nTests, numErrors);
		if (numErrors == 0 && nTests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		nTests++;
		if (g !== e) begin
			numErrors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Single word transfer; read data taken at the data-phase edge
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic ctl(input int md, input int d, input logic s);
		ahb(1'b1, `FE_CTRL_OFS, {25'h0, s, 2'(d), 4'(md)});
		star <= s;
	endtask

	function automatic logic [47:0] vl(input logic [2:0] low);
		for (int i = 0; i < 3; i++) vl[16*i +: 16] = low[i] ? 16'h0064 : 16'h2710;
	endfunction

	function automatic logic exp_pick(input int md, input int fq);
		if (md == 1 || md == 3 || md == 5) return fq < P;
		if (md == 2 || md == 4 || md == 6) return fq > P;
		return 1'b0;
	endfunction

	function automatic logic exp_grad(input int d, input int st);
		return d >= 2 || (d == 0 && st > 0) || (d == 1 && st < 0);
	endfunction

	task automatic setf(input int fq, input logic [2:0] low);
		@(posedge clk);
		f = fq;
		freqs <= {3{16'(fq)}};
		volts <= vl(low);
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Frequency steps right after each strobe has been taken
	task automatic ramp(input int st, input int n);
		repeat (n) begin
			do begin
				@(posedge clk);
				#1;
			end while (ppd[0] !== 1'b1);
			@(posedge clk);
			f = f + st;
			freqs <= {3{16'(f)}};
		end
	endtask

	// Pickup with some channels low or the external block raised
	task automatic blk(input int md, input logic [2:0] low, input logic ext, input logic e);
		ctl(md, 0, 1'b1);
		extBlock <= ext;
		setf(P, 3'b000);
		@(posedge clk);
		freqs <= {16'd48000, 16'd49000, 16'd47000};
		volts <= vl(low);
		wt(DLY + 3);
		chk("alarm", e, alarm);
		chk("trip", e, trip);
		ahb(1'b0, `FE_STATUS_OFS, 32'h0);
		chk("blocked", !e, rd[4]);
		chk("status", {e, e}, rd[1:0]);
		if (e) chk("average", 32'hbd74, rd >> 16);
		extBlock <= 1'b0;
		setf(P, 3'b000);
	endtask

	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		htrans = 2'b00;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		extBlock = 1'b0;
		star = 1'b1;
		volts = vl(3'b000);
		freqs = {3{16'(P)}};
		rd = $urandom(32'h9be0);
		ofs = '{`FE_CTRL_OFS, `FE_PICKUP_OFS, `FE_GRAD_OFS, `FE_CHANGE_OFS, `FE_DELAY_OFS,
			`FE_INTERVAL_OFS, `FE_UVLEVEL_OFS};
		rsv = '{`FE_CTRL_RST, `FE_PICKUP_RST, `FE_GRAD_RST, `FE_CHANGE_RST, `FE_DELAY_RST,
			`FE_INTERVAL_RST, `FE_UVLEVEL_RST};
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		// Reset values, an unmapped place, a random write
		for (int i = 0; i < 7; i++) begin
			ahb(1'b0, ofs[i], 32'h0);
			chk("reset value", rsv[i], rd);
		end
		ahb(1'b1, 8'h20, 32'hffff_ffff);
		ahb(1'b0, 8'h20, 32'h0);
		chk("unmapped", 32'h0, rd);
		f = $urandom;
		ahb(1'b1, `FE_CHANGE_OFS, f);
		ahb(1'b0, `FE_CHANGE_OFS, 32'h0);
		chk("change", f & 32'hffff, rd);
		ahb(1'b1, `FE_CHANGE_OFS, `FE_CHANGE_RST);
		ahb(1'b1, `FE_DELAY_OFS, DLY);
		ahb(1'b1, `FE_INTERVAL_OFS, IVL);
		$display("Registers done");
		// Under and over pickup with delay, both wirings
		for (int s = 0; s < 2; s++) begin
			for (m = 1; m < 3; m++) begin
				ctl(m, 0, 1'(s));
				setf(P, 3'b000);
				setf((m == 1) ? P - 1000 : P + 1000, 3'b000);
				wt(1);
				chk("alarm", 1'b1, alarm);
				wt(DLY);
				chk("trip", 1'b0, trip);
				wt(1);
				chk("trip", 1'b1, trip);
				setf(P, 3'b000);
				wt(1);
				chk("alarm", 1'b0, alarm);
			end
		end
		for (int i = 0; i < 12; i++) begin
			m = 1 + $urandom % 2;
			ctl(m, 0, 1'b1);
			setf(P - 5000 + $urandom % 10000, 3'b000);
			wt(1);
			chk("alarm", exp_pick(m, f), alarm);
			setf(P, 3'b000);
		end
		$display("Frequency pickup done");
		blk(1, 3'b001, 1'b0, 1'b1);
		blk(1, 3'b111, 1'b0, 1'b0);
		blk(1, 3'b000, 1'b1, 1'b0);
		blk(5, 3'b001, 1'b0, 1'b0);
		$display("Blocking done");
		// Gradient sign run, direction setting and persistence
		for (int d = 0; d < 4; d++) begin
			for (sg = -1000; sg <= 1000; sg += 2000) begin
				ctl(7, d, 1'b1);
				setf(P, 3'b000);
				ramp(0, 3);
				ramp(sg, 3);
				wt(3);
				chk("alarm", 1'b0, alarm);
				ramp(sg, 4);
				wt(3);
				chk("alarm", exp_grad(d, sg), alarm);
				chk("trip", exp_grad(d, sg), trip);
				ramp(0, 2);
				wt(3);
				chk("alarm", 1'b0, alarm);
			end
		end
		$display("Gradient done");
		// Frequency and gradient must hold together
		for (m = 3; m < 5; m++) begin
			sg = (m == 3) ? -1000 : 1000;
			ctl(m, 2, 1'b1);
			setf(P - 9 * sg / 2, 3'b000);
			ramp(0, 2);
			for (int k = 1; k < 9; k++) begin
				ramp(sg, 1);
				wt(3);
				if (k > 3) chk("alarm", exp_pick(m, f), alarm);
			end
			chk("trip", 1'b1, trip);
			setf(P, 3'b000);
			wt(1);
			chk("trip", 1'b0, trip);
		end
		$display("Combined done");
		// Interval: trip on enough change, inhibit after expiry
		for (m = 5; m < 7; m++) begin
			sg = (m == 5) ? -1 : 1;
			ctl(m, 0, 1'b1);
			setf(P, 3'b000);
			setf(P + 100 * sg, 3'b000);
			wt(1);
			chk("alarm", 1'b1, alarm);
			setf(P + 1200 * sg, 3'b000);
			wt(3);
			chk("trip", 1'b1, trip);
			setf(P, 3'b000);
			setf(P + 100 * sg, 3'b000);
			wt(IVL + 5);
			chk("alarm", 1'b0, alarm);
			ahb(1'b0, `FE_STATUS_OFS, 32'h0);
			chk("state", 32'h3, rd[7:6]);
			setf(P + 2000 * sg, 3'b000);
			wt(3);
			chk("trip", 1'b0, trip);
			setf(P, 3'b000);
			setf(P + 100 * sg, 3'b000);
			wt(1);
			chk("alarm", 1'b1, alarm);
			setf(P, 3'b000);
		end
		for (m = 0; m < 9; m += 8) begin
			ctl(m, 0, 1'b1);
			setf(P - 9000, 3'b000);
			wt(DLY + 3);
			chk("alarm", 1'b0, alarm);
		end
		$display("Interval done");
		chk("hresp", 1'b0, hresp);
		chk("hreadyout", 1'b1, hreadyout);
		close_out();
	end
endmodule // frequency_protection_element_tb

`default_nettype wire
